// ===== rtl/dacwd_pkg.sv
// Package for the serial data-register write decoder: frame layout, codes, reset values
`default_nettype none

package dacwd_pkg;

  // Frame lengths in serial clocks
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned FRAME_BITS_CHECKED = 32;
  localparam int unsigned CHECK_BITS = FRAME_BITS_CHECKED - FRAME_BITS;
  localparam logic [5:0] LAST_BIT_PLAIN = 6'h17;
  localparam logic [5:0] LAST_BIT_CHECKED = 6'h1f;

  // Number of channels
  localparam int unsigned NUM_CHANNELS = 4;

  // Access direction bit values
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ = 1'h1;

  // Register-select codes
  localparam logic [2:0] SEL_CONV_ONE = 3'h0;
  localparam logic [2:0] SEL_RESERVED = 3'h1;
  localparam logic [2:0] SEL_GAIN_ONE = 3'h2;
  localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
  localparam logic [2:0] SEL_OFFS_ONE = 3'h4;
  localparam logic [2:0] SEL_OFFS_ALL = 3'h5;
  localparam logic [2:0] SEL_CLR_ONE = 3'h6;
  localparam logic [2:0] SEL_CONTROL = 3'h7;

  // Data field positions inside the 16-bit payload
  localparam int unsigned CODE_MSB = 15;
  localparam int unsigned CODE_LSB = 4;
  localparam int unsigned CTRL_SEL_MSB = 15;
  localparam int unsigned CTRL_SEL_LSB = 13;
  localparam int unsigned CTRL_DATA_MSB = 12;

  // Low nibble fill written beside a 12-bit code
  localparam logic [3:0] GAIN_FILL = 4'hf;
  localparam logic [3:0] PLAIN_FILL = 4'h0;

  // Reset values of the channel registers
  localparam logic [15:0] CONV_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET = 16'hffff;
  localparam logic [15:0] OFFS_RESET = 16'h8000;
  localparam logic [15:0] CLR_RESET = 16'h0000;

  // Fields of one 24-bit command frame, most significant first
  typedef struct packed {
    logic rw;                    // Access direction
    logic device_select_hi;      // Must match upper strap
    logic device_select_lo;      // Must match lower strap
    logic [2:0] register_select; // Target register kind
    logic channel_select_hi;     // Channel number, upper bit
    logic channel_select_lo;     // Channel number, lower bit
    logic [15:0] data;           // Payload
  } dacwd_frame_t;

  // Per-channel data-side registers
  typedef struct packed {
    logic [15:0] conversion_code;
    logic [15:0] gain_trim;
    logic [15:0] offset_trim;
    logic [15:0] clear_code;
  } dacwd_chan_regs_t;

  // Control-register write handed on to control decoding
  typedef struct packed {
    logic [2:0] control_select;
    logic [1:0] channel;
    logic [12:0] data;
  } dacwd_ctrl_wr_t;

  // Read request handed on to readback framing
  typedef struct packed {
    logic [2:0] register_select;
    logic [1:0] channel;
    logic [15:0] data;
  } dacwd_rd_req_t;

endpackage : dacwd_pkg

`default_nettype wire

// ===== rtl/dacwd_sync.sv
// Three-stage synchroniser for levels that enter from another clock domain
`default_nettype none

module dacwd_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk,
  input wire logic resetn,
  // Asynchronous level in
  input wire logic [WIDTH-1:0] d,
  // Second and third stages out
  output logic [WIDTH-1:0] q2,
  output logic [WIDTH-1:0] q3
);

  logic [WIDTH-1:0] s1_q; // First stage, read by the second only

  // Three flops in a row; callers compare the second and third
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      q2 <= '0;
      q3 <= '0;
    end else begin
      s1_q <= d;
      q2 <= s1_q;
      q3 <= q2;
    end
  end

endmodule : dacwd_sync

`default_nettype wire

// ===== rtl/dacwd_decoder.sv
// Serial write-frame decoder for the four channels' data-side registers
`default_nettype none

module dacwd_decoder
  import dacwd_pkg::*;
(
  // System clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Serial link
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  // Address straps and frame-length option
  input wire logic strap_addr_hi_pin,
  input wire logic strap_addr_lo_pin,
  input wire logic packet_check_en,
  // Channel register contents
  output dacwd_chan_regs_t [NUM_CHANNELS-1:0] chan_regs,
  // Control-register writes for the control decoder
  output logic ctrl_wr_valid,
  output dacwd_ctrl_wr_t ctrl_wr,
  // Read requests for the readback logic
  output logic rd_req_valid,
  output dacwd_rd_req_t rd_req,
  // Frame accepted for this device
  output logic frame_hit
);

  //////////////////////////////////////////////////////////////////////////////
  // Link side: serial shift on the serial clock
  //////////////////////////////////////////////////////////////////////////////

  logic frame_rst_n;          // Clears the bit count between frames
  logic [31:0] shift_q;       // Incoming bits, newest in bit 0
  logic [5:0] bit_cnt_q;      // Bits taken in this frame
  logic [5:0] last_bit;       // Index of the last frame bit
  logic last_edge;            // This edge takes the final bit
  logic [23:0] word_d;        // Command part of the completed frame
  logic [FRAME_BITS-1:0] word_q; // Held completed frame
  logic frame_tgl_q;          // Flips once per completed frame
  logic pc_s2;                // Check option, second stage
  logic pc_s3;                // Check option, third stage
  logic pc_q;                 // Check option as seen by the link

  // Count clears whenever the frame strobe is high or the device resets
  assign frame_rst_n = resetn & ~sync_n;

  // Frame-length option brought across into the link domain
  dacwd_sync #(
    .WIDTH(1)
  ) u_pc_sync (
    .clk(sclk),
    .resetn(resetn),
    .d(packet_check_en),
    .q2(pc_s2),
    .q3(pc_s3)
  );

  // Option takes effect once the last two stages agree
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      pc_q <= 1'h0;
    end else if (pc_s2 == pc_s3) begin
      pc_q <= pc_s3;
    end
  end

  // Length of the frame in use
  assign last_bit = pc_q ? LAST_BIT_CHECKED : LAST_BIT_PLAIN;
  assign last_edge = (bit_cnt_q == last_bit);

  // Bit counter, stops after the last bit so extra clocks are ignored
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 6'h00;
    end else if (bit_cnt_q <= last_bit) begin
      bit_cnt_q <= bit_cnt_q + 6'h01;
    end
  end

  // Shift register, most significant bit first
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 32'h00000000;
    end else begin
      shift_q <= {shift_q[30:0], sdin};
    end
  end

  // Check code trails the command and is dropped here
  always_comb begin
    if (pc_q) begin
      word_d = shift_q[30:7];
    end else begin
      word_d = {shift_q[22:0], sdin};
    end
  end

  // Hold the completed command and announce it by a toggle
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      word_q <= 24'h000000;
      frame_tgl_q <= 1'h0;
    end else if (last_edge && !sync_n) begin
      word_q <= word_d;
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock
  //////////////////////////////////////////////////////////////////////////////

  logic tgl_s2;               // Frame toggle, second stage
  logic tgl_s3;               // Frame toggle, third stage
  logic tgl_seen_q;           // Last toggle value acted on
  logic frame_evt;            // One-cycle pulse per new frame
  logic [1:0] strap_s2;       // Straps, second stage
  logic [1:0] strap_s3;       // Straps, third stage
  logic [1:0] strap_q;        // Settled strap levels

  // Frame toggle synchroniser
  dacwd_sync #(
    .WIDTH(1)
  ) u_tgl_sync (
    .clk(clk),
    .resetn(resetn),
    .d(frame_tgl_q),
    .q2(tgl_s2),
    .q3(tgl_s3)
  );

  // Strap pin synchroniser
  dacwd_sync #(
    .WIDTH(2)
  ) u_strap_sync (
    .clk(clk),
    .resetn(resetn),
    .d({strap_addr_hi_pin, strap_addr_lo_pin}),
    .q2(strap_s2),
    .q3(strap_s3)
  );

  // New frame once the settled toggle differs from the one acted on
  assign frame_evt = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen_q);

  // Remember which toggle has been handled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tgl_seen_q <= 1'h0;
    end else if (frame_evt) begin
      tgl_seen_q <= tgl_s3;
    end
  end

  // Straps are taken once the last two stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_q <= 2'h0;
    end else if (strap_s2 == strap_s3) begin
      strap_q <= strap_s3;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  //////////////////////////////////////////////////////////////////////////////

  dacwd_frame_t frame;        // Held frame viewed as fields
  logic addressed;            // Device address matches the straps
  logic wr_evt;               // Write frame for this device
  logic [1:0] chan;           // Selected channel
  logic [15:0] code_plain;    // Code with zero low nibble
  logic [15:0] code_gain;     // Code with ones low nibble
  logic [NUM_CHANNELS-1:0] wr_conv; // Per-channel conversion write
  logic [NUM_CHANNELS-1:0] wr_gain; // Per-channel gain write
  logic [NUM_CHANNELS-1:0] wr_offs; // Per-channel offset write
  logic [NUM_CHANNELS-1:0] wr_clr;  // Per-channel clear code write

  // Word is stable while its toggle crosses, so it is read directly
  assign frame = dacwd_frame_t'(word_q);

  // Straps select which of up to four devices answers
  assign addressed = ({frame.device_select_hi, frame.device_select_lo} == strap_q);
  assign wr_evt = frame_evt && addressed && (frame.rw == DIR_WRITE);
  assign chan = {frame.channel_select_hi, frame.channel_select_lo};

  // Only bits 15..4 carry the code; bits 3..0 are replaced
  assign code_plain = {frame.data[CODE_MSB:CODE_LSB], PLAIN_FILL};
  assign code_gain = {frame.data[CODE_MSB:CODE_LSB], GAIN_FILL};

  // Per-channel write strobes from the register-select code
  always_comb begin
    wr_conv = '0;
    wr_gain = '0;
    wr_offs = '0;
    wr_clr = '0;
    if (wr_evt) begin
      unique case (frame.register_select)
        // Single-channel conversion code
        SEL_CONV_ONE: begin
          wr_conv[chan] = 1'h1;
        end
        // Reserved: nothing changes
        SEL_RESERVED: begin
          wr_conv = '0;
        end
        // Single-channel gain trim
        SEL_GAIN_ONE: begin
          wr_gain[chan] = 1'h1;
        end
        // Broadcast gain trim, channel bits ignored
        SEL_GAIN_ALL: begin
          wr_gain = '1;
        end
        // Single-channel offset trim
        SEL_OFFS_ONE: begin
          wr_offs[chan] = 1'h1;
        end
        // Broadcast offset trim, channel bits ignored
        SEL_OFFS_ALL: begin
          wr_offs = '1;
        end
        // Single-channel clear code
        SEL_CLR_ONE: begin
          wr_clr[chan] = 1'h1;
        end
        // Control writes go elsewhere
        SEL_CONTROL: begin
          wr_clr = '0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel registers
  //////////////////////////////////////////////////////////////////////////////

  dacwd_chan_regs_t [NUM_CHANNELS-1:0] regs_q; // All channel registers

  // One register set per channel
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
    // Conversion code
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        regs_q[ch].conversion_code <= CONV_RESET;
      end else if (wr_conv[ch]) begin
        regs_q[ch].conversion_code <= code_plain;
      end
    end

    // Gain trim, 12 unsigned bits in steps of one
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        regs_q[ch].gain_trim <= GAIN_RESET;
      end else if (wr_gain[ch]) begin
        regs_q[ch].gain_trim <= code_gain;
      end
    end

    // Offset trim, midpoint 0x8000 means no adjustment
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        regs_q[ch].offset_trim <= OFFS_RESET;
      end else if (wr_offs[ch]) begin
        regs_q[ch].offset_trim <= code_plain;
      end
    end

    // Clear code
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        regs_q[ch].clear_code <= CLR_RESET;
      end else if (wr_clr[ch]) begin
        regs_q[ch].clear_code <= code_plain;
      end
    end
  end

  assign chan_regs = regs_q;

  //////////////////////////////////////////////////////////////////////////////
  // Hand-offs to control decoding and readback
  //////////////////////////////////////////////////////////////////////////////

  logic ctrl_wr_valid_q;      // Control write pulse
  dacwd_ctrl_wr_t ctrl_wr_q;  // Control write fields
  logic rd_req_valid_q;       // Read request pulse
  dacwd_rd_req_t rd_req_q;    // Read request fields
  logic frame_hit_q;          // Addressed-frame pulse

  // Control write: control-select field picks the target register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_wr_valid_q <= 1'h0;
      ctrl_wr_q <= '0;
    end else begin
      ctrl_wr_valid_q <= wr_evt && (frame.register_select == SEL_CONTROL);
      if (wr_evt && (frame.register_select == SEL_CONTROL)) begin
        ctrl_wr_q.control_select <= frame.data[CTRL_SEL_MSB:CTRL_SEL_LSB];
        ctrl_wr_q.channel <= chan;
        ctrl_wr_q.data <= frame.data[CTRL_DATA_MSB:0];
      end
    end
  end

  // Read frames change nothing here and are passed on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_req_valid_q <= 1'h0;
      rd_req_q <= '0;
    end else begin
      rd_req_valid_q <= frame_evt && addressed && (frame.rw == DIR_READ);
      if (frame_evt && addressed && (frame.rw == DIR_READ)) begin
        rd_req_q.register_select <= frame.register_select;
        rd_req_q.channel <= chan;
        rd_req_q.data <= frame.data;
      end
    end
  end

  // Pulse for every frame this device accepted
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_hit_q <= 1'h0;
    end else begin
      frame_hit_q <= frame_evt && addressed;
    end
  end

  assign ctrl_wr_valid = ctrl_wr_valid_q;
  assign ctrl_wr = ctrl_wr_q;
  assign rd_req_valid = rd_req_valid_q;
  assign rd_req = rd_req_q;
  assign frame_hit = frame_hit_q;

endmodule : dacwd_decoder

`default_nettype wire

// ===== tb/dacwd_decoder_sva.sv
// Concurrent checks on the decoder's ports
`default_nettype none

module dacwd_decoder_sva
  import dacwd_pkg::*;
(
  // Clocks and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  // Serial link, straps and option
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic strap_addr_hi_pin,
  input wire logic strap_addr_lo_pin,
  input wire logic packet_check_en,
  // Outputs under watch
  input wire dacwd_chan_regs_t [NUM_CHANNELS-1:0] chan_regs,
  input wire logic ctrl_wr_valid,
  input wire dacwd_ctrl_wr_t ctrl_wr,
  input wire logic rd_req_valid,
  input wire dacwd_rd_req_t rd_req,
  input wire logic frame_hit
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////
  // Per-field views of the channel registers
  logic [3:0][15:0] gain_v, offs_v, conv_v, clr_v;
  logic fill_ok; // Low nibbles hold their fill
  always_comb begin
    fill_ok = 1'h1;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      gain_v[i] = chan_regs[i].gain_trim;
      offs_v[i] = chan_regs[i].offset_trim;
      conv_v[i] = chan_regs[i].conversion_code;
      clr_v[i] = chan_regs[i].clear_code;
      fill_ok = fill_ok && gain_v[i][3:0] == 4'hf && offs_v[i][3:0] == 4'h0 &&
                conv_v[i][3:0] == 4'h0 && clr_v[i][3:0] == 4'h0;
    end
  end

  ////////////////////////////////////////
  a_hit_spacing: assert property (frame_hit |=> !frame_hit [*8])
    else $error("frame hit too long or too close");
  a_read_no_write: assert property (rd_req_valid |-> frame_hit && $stable(chan_regs))
    else $error("read frame changed a register");
  a_ctrl_no_write: assert property (
    ctrl_wr_valid |-> frame_hit && !rd_req_valid && $stable(chan_regs))
    else $error("control write changed a channel register");
  a_write_needs_hit: assert property (
    $changed(chan_regs) |-> frame_hit && !rd_req_valid && !ctrl_wr_valid)
    else $error("register changed without a hit");
  a_low_fill: assert property (fill_ok)
    else $error("low nibble fill wrong");
  a_gain_broadcast: assert property (
    $changed(gain_v[0]) && $changed(gain_v[2]) |->
      gain_v[0] == gain_v[1] && gain_v[1] == gain_v[2] && gain_v[2] == gain_v[3])
    else $error("gain broadcast not equal");
  a_offs_broadcast: assert property (
    $changed(offs_v[1]) && $changed(offs_v[3]) |->
      offs_v[0] == offs_v[1] && offs_v[1] == offs_v[2] && offs_v[2] == offs_v[3])
    else $error("offset broadcast not equal");
  a_conv_one_chan: assert property ($onehot0({$changed(conv_v[0]),
    $changed(conv_v[1]), $changed(conv_v[2]), $changed(conv_v[3])}))
    else $error("code write hit several channels");
  a_clear_one_chan: assert property ($onehot0({$changed(clr_v[0]),
    $changed(clr_v[1]), $changed(clr_v[2]), $changed(clr_v[3])}))
    else $error("clear code write hit several channels");

endmodule : dacwd_decoder_sva

bind dacwd_decoder dacwd_decoder_sva chk_u (
  .clk(clk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
  .strap_addr_hi_pin(strap_addr_hi_pin), .strap_addr_lo_pin(strap_addr_lo_pin),
  .packet_check_en(packet_check_en), .chan_regs(chan_regs),
  .ctrl_wr_valid(ctrl_wr_valid), .ctrl_wr(ctrl_wr), .rd_req_valid(rd_req_valid),
  .rd_req(rd_req), .frame_hit(frame_hit)
);

`default_nettype wire

// ===== tb/dacwd_host.sv
// Behavioural serial host that sends command frames to the decoder
`default_nettype none

module dacwd_host (
  // Serial link toward the decoder
  output var logic sclk,
  output var logic sync_n,
  output var logic sdin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle link: clock parked high, strobe high
  initial begin
    sclk = 1'h1;
    sync_n = 1'h1;
    sdin = 1'h0;
  end

  // Send the low n bits of w, most significant first; a short n cuts a frame
  task automatic send(input logic [31:0] w, input int n);
    sync_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'h1;
      sdin = w[i];
      #40;
      sclk = 1'h0;
      #40;
    end
    sclk = 1'h1;
    #40;
    sync_n = 1'h1;
    sdin = ~sdin; // Released line must not show a stale bit
    #80;
  endtask : send

endmodule : dacwd_host

`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the serial write-frame decoder
`default_nettype none

module tb;
  import dacwd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and pins driven by the bench
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [1:0] strap = 2'h0;
  logic pc_en = 1'h0;
  wire logic sclk, sync_n, sdin; // From the host model
  // Decoder outputs
  dacwd_chan_regs_t [NUM_CHANNELS-1:0] chan_regs;
  logic ctrl_wr_valid, rd_req_valid, frame_hit;
  dacwd_ctrl_wr_t ctrl_wr;
  dacwd_rd_req_t rd_req;
  // Expected state and tallies
  dacwd_chan_regs_t [NUM_CHANNELS-1:0] exp_regs;
  dacwd_ctrl_wr_t exp_ctrl = '0;
  dacwd_rd_req_t exp_rd = '0;
  int hits = 0, ctrls = 0, rds = 0, exp_hits = 0, exp_ctrls = 0, exp_rds = 0;
  int bad_count = 0, tests_run = 0;
  int seed = 55806;
  logic [31:0] r;
  logic [15:0] lim [3] = '{16'h000f, 16'hfff5, 16'h800a}; // Trim extremes, junk low bits

  always #2 clk = ~clk;

  dacwd_host host_u (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));

  dacwd_decoder dut_u (
    .clk(clk), .resetn(resetn), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
    .strap_addr_hi_pin(strap[1]), .strap_addr_lo_pin(strap[0]), .packet_check_en(pc_en),
    .chan_regs(chan_regs), .ctrl_wr_valid(ctrl_wr_valid), .ctrl_wr(ctrl_wr),
    .rd_req_valid(rd_req_valid), .rd_req(rd_req), .frame_hit(frame_hit)
  );

  // Tally the one-cycle pulses
  always @(posedge clk) begin
    if (frame_hit === 1'h1) hits++;
    if (ctrl_wr_valid === 1'h1) ctrls++;
    if (rd_req_valid === 1'h1) rds++;
  end

  ////////////////////////////////////////
  function automatic logic [15:0] rnd();
    logic [31:0] v;
    v = $random(seed);
    return v[15:0];
  endfunction : rnd

  function automatic dacwd_frame_t mk(input logic rw, input logic [1:0] dev,
      input logic [2:0] sel, input logic [1:0] ch, input logic [15:0] d);
    return {rw, dev, sel, ch, d};
  endfunction : mk

  // Work out what one complete frame should do
  function automatic void predict(input dacwd_frame_t f);
    logic [1:0] ch;
    logic [15:0] code;
    logic [15:0] gain;
    ch = {f.channel_select_hi, f.channel_select_lo};
    code = {f.data[CODE_MSB:CODE_LSB], PLAIN_FILL};
    gain = {f.data[CODE_MSB:CODE_LSB], GAIN_FILL};
    if ({f.device_select_hi, f.device_select_lo} != strap) return;
    exp_hits++;
    if (f.rw == DIR_READ) begin
      exp_rds++;
      exp_rd = '{f.register_select, ch, f.data};
      return;
    end
    case (f.register_select)
      SEL_CONV_ONE: exp_regs[ch].conversion_code = code;
      SEL_GAIN_ONE: exp_regs[ch].gain_trim = gain;
      SEL_OFFS_ONE: exp_regs[ch].offset_trim = code;
      SEL_CLR_ONE: exp_regs[ch].clear_code = code;
      SEL_GAIN_ALL, SEL_OFFS_ALL: begin
        for (int i = 0; i < NUM_CHANNELS; i++) begin
          if (f.register_select == SEL_GAIN_ALL) exp_regs[i].gain_trim = gain;
          else exp_regs[i].offset_trim = code;
        end
      end
      SEL_CONTROL: begin
        exp_ctrls++;
        exp_ctrl = '{f.data[15:13], ch, f.data[12:0]};
      end
      default: ;
    endcase
  endfunction : predict

  ////////////////////////////////////////
  task automatic chk_regs(input string what);
    tests_run++;
    if (chan_regs !== exp_regs) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp_regs, chan_regs);
    end
  endtask : chk_regs

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  // Send one whole frame at the current length, then compare everything
  task automatic run(input dacwd_frame_t f);
    predict(f);
    if (pc_en) host_u.send({f, 8'h5a}, FRAME_BITS_CHECKED);
    else host_u.send({8'h00, f}, FRAME_BITS);
    chk_regs("chan_regs");
    chk_val("hits", exp_hits, hits);
    chk_val("ctrl count", exp_ctrls, ctrls);
    chk_val("ctrl_wr", exp_ctrl, ctrl_wr);
    chk_val("read count", exp_rds, rds);
    chk_val("rd_req", exp_rd, rd_req);
  endtask : run

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      exp_regs[i] = {CONV_RESET, GAIN_RESET, OFFS_RESET, CLR_RESET};
    end
    repeat (5) @(posedge clk);
    #1 resetn = 1'h1;
    repeat (8) @(posedge clk);
    chk_regs("reset regs");
    // Every select code, then again with the channel bits turned round
    for (int s = 0; s < 16; s++) begin
      run(mk(DIR_WRITE, strap, s[2:0], s[3] ? ~s[1:0] : s[1:0], rnd()));
    end
    // Trim extremes; the half-range gain limit is host advice, so these must still land
    for (int k = 0; k < 3; k++) begin
      run(mk(DIR_WRITE, strap, SEL_GAIN_ONE, 2'h3, lim[k]));
      run(mk(DIR_WRITE, strap, SEL_OFFS_ALL, 2'h1, lim[k]));
    end
    // Each strap setting, matched and missed
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      #1 strap = d[1:0];
      repeat (8) @(posedge clk);
      run(mk(DIR_WRITE, d[1:0], SEL_CONV_ONE, d[1:0], rnd()));
      run(mk(DIR_WRITE, ~d[1:0], SEL_GAIN_ALL, d[1:0], rnd()));
      run(mk(DIR_READ, d[1:0], d[2:0] + 3'h3, d[1:0], rnd()));
    end
    // Long frames: warm up the option, a 24-bit frame is then cut short
    @(posedge clk);
    #1 pc_en = 1'h1;
    host_u.send(32'h0, 4);
    host_u.send({8'h00, mk(DIR_WRITE, strap, SEL_CONV_ONE, 2'h2, 16'h1230)}, FRAME_BITS);
    chk_regs("cut frame");
    for (int k = 0; k < 4; k++) begin
      run(mk(DIR_WRITE, strap, SEL_CLR_ONE, k[1:0], rnd()));
    end
    @(posedge clk);
    #1 pc_en = 1'h0;
    host_u.send(32'h0, 4);
    // Random frames, half of them aimed at this device
    for (int k = 0; k < 30; k++) begin
      r = $random(seed);
      if (r[31]) r[22:21] = strap;
      run(r[23:0]);
    end
    report_and_stop();
  end

  // Watchdog against a hung run
  initial begin
    #300000;
    bad_count++;
    $display("wrong value watchdog expected finish seen timeout");
    report_and_stop();
  end

endmodule : tb

`default_nettype wire
